// file: gih_pkg.sv
// Shared constants and carrier types for the grouped interrupt and halt control block.
// Assumes a single 100 MHz system clock domain and an active-low asynchronous reset.
package gih_pkg;

    // ==========================================================================
    // Sizing
    localparam int GIH_GROUPS = 4;
    localparam int GIH_TIMERS = 3;
    localparam int GIH_VEC_W = 12;
    localparam int GIH_DEPTH = 8;

    // ==========================================================================
    // Vector addresses, in ascending order; group n uses base plus n times step.
    localparam logic [11:0] GIH_VEC_BASE = 12'h00c;
    localparam logic [11:0] GIH_VEC_STEP = 12'h004;

    // ==========================================================================
    // Source layout inside a group and reset values.
    localparam int GIH_SRC_W = 3;
    localparam logic [3:0] GIH_EN_RESET = 4'h0;
    localparam logic GIH_PDF_RESET = 1'b0;
    localparam logic GIH_TO_RESET = 1'b0;

    // Processor sequencer commands.
    typedef enum logic [1:0] {
        GIH_CMD_NONE,
        GIH_CMD_RET,
        GIH_CMD_RETURN_WITH_IRQ_ENABLE,
        GIH_CMD_HALT
    } gih_cmd_t;

    // Per-timer match events or flags: period, match A, match B.
    typedef struct packed {
        logic match_b;
        logic match_a;
        logic period;
    } gih_tm_t;

    // Vector call presented to the sequencer.
    typedef struct packed {
        logic valid;
        logic [GIH_VEC_W-1:0] addr;
    } gih_call_t;

endpackage

// file: gih_flag.sv
// One sticky request flag: hardware sets, software clears, set wins.
// Assumes set and clear are synchronous to the system clock.
`timescale 1ns/100ps
`default_nettype none
module gih_flag (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic set,
    input wire logic clr,
    output logic flag,
    output logic rise
);
    logic next_flag;
    assign next_flag = set | (flag & ~clr);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flag <= 1'b0;
            rise <= 1'b0;
        end else begin
            flag <= next_flag;
            rise <= next_flag & ~flag;
        end
    end
endmodule
`default_nettype wire

// file: gih_prio.sv
// Fixed priority pick among eligible group requests, lowest vector first.
// Purely combinational; the caller registers the result.
`timescale 1ns/100ps
`default_nettype none
module gih_prio
    import gih_pkg::*;
#(
    parameter int N = GIH_GROUPS
) (
    input wire logic [N-1:0] req,
    output logic any,
    output logic [N-1:0] grant
);
    logic [N-1:0] lower;
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_p
            if (i == 0) begin : g_z
                assign lower[i] = 1'b0;
            end else begin : g_n
                assign lower[i] = lower[i-1] | req[i-1];
            end
            assign grant[i] = req[i] & ~lower[i];
        end
    endgenerate
    assign any = |req;
endmodule
`default_nettype wire

// file: gih_ctrl.sv
// Grouped interrupt controller with halt handling for a small microcontroller core.
// Assumes the core sequencer acts on VEC_CALL, pushes only the PC and reports RET, RETURN_WITH_IRQ_ENABLE and HALT.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Write-done flag sets at write end
// - Low-supply flag sets on detector report
// - Two timer flags, three for enhanced
// - Timer flag sets on P/A/B match
// - Call needs all enables, stack room, request
// - Service clears global enable, group flag only
// - Flags stay set while disabled
// - Any flag rise wakes from halt
// - Service pushes only program counter
// - Return-with-enable pops, sets global enable
// - Plain return pops, enable stays clear
// - Halt only by instruction, clock stops
// - Halt keeps memory, registers, ports
// - Halt clears watchdog, sub-clock keeps counting
// - Halt sets power-down, clears timeout
// - Group flag sets when member sets
// - Blocked wake resumes after halt
module gih_ctrl
    import gih_pkg::*;
#(
    parameter int NT = GIH_TIMERS,
    parameter logic [NT-1:0] TM_ENH = 3'b100
) (
    input wire logic REF_CLK,
    input wire logic RST_B,
    // Event sources: synchronous pulses from peripherals, except the low supply detector level, which is synchronised below.
    input wire logic STORE_WRITE_DONE,
    input wire logic LOW_SUPPLY_DET,
    input wire gih_tm_t [NT-1:0] TM_MATCH,
    // Software enables.
    input wire logic GLOBAL_IRQ_ENABLE_SET,
    input wire logic GLOBAL_IRQ_ENABLE_CLR,
    input wire logic STORAGE_WRITE_DONE_ENABLE,
    input wire logic LOW_SUPPLY_ENABLE,
    input wire gih_tm_t [NT-1:0] TM_ENABLE,
    input wire logic [GIH_GROUPS-1:0] GROUP_IRQ_ENABLE,
    // Software flag writes: set forces high, clear drops.
    input wire logic STORAGE_WRITE_DONE_CLR,
    input wire logic LOW_SUPPLY_CLR,
    input wire logic LOW_SUPPLY_SET,
    input wire gih_tm_t [NT-1:0] TM_FLAG_CLR,
    input wire gih_tm_t [NT-1:0] TM_FLAG_SET,
    input wire logic [GIH_GROUPS-1:0] GROUP_FLAG_CLR,
    // Core sequencer.
    input wire gih_cmd_t CORE_CMD,
    input wire logic STACK_FULL,
    input wire logic CLR_WDT,
    input wire logic WDT_ENABLE,
    input wire logic WDT_FROM_SUB_CLOCK,
    output gih_call_t VEC_CALL,
    output logic PUSH_PC,
    output logic POP_PC,
    output logic GLOBAL_IRQ_ENABLE,
    output logic HALTED,
    output logic SYS_CLK_RUN,
    output logic WAKE_RESUME,
    output logic WDT_CLEAR,
    output logic WDT_RUN,
    output logic POWER_DOWN_STATUS,
    output logic WATCHDOG_TIMEOUT_STATUS,
    input wire logic WDT_OVERFLOW,
    output logic STORAGE_WRITE_DONE_FLAG,
    output logic LOW_SUPPLY_FLAG,
    output gih_tm_t [NT-1:0] TM_FLAG,
    output logic [GIH_GROUPS-1:0] GROUP_REQUEST_FLAGS
);
    // ==========================================================================
    // Low supply detector comes from an analog block: synchronise it.
    logic lv_s1, lv_s2, lv_s3;
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            lv_s1 <= 1'b0;
            lv_s2 <= 1'b0;
            lv_s3 <= 1'b0;
        end else begin
            lv_s1 <= LOW_SUPPLY_DET;
            lv_s2 <= lv_s1;
            lv_s3 <= lv_s2;
        end
    end
    wire lv_event = lv_s2 & ~lv_s3;

    // ==========================================================================
    // Source flags. Index 0 write done, 1 low supply, then timers three apiece.
    localparam int NS = 2 + GIH_SRC_W * NT;
    logic [NS-1:0] src_set, src_clr, src_flag, src_rise, src_en;
    assign src_set[0] = STORE_WRITE_DONE;
    assign src_set[1] = lv_event | LOW_SUPPLY_SET;
    assign src_clr[0] = STORAGE_WRITE_DONE_CLR;
    assign src_clr[1] = LOW_SUPPLY_CLR;
    assign src_en[0] = STORAGE_WRITE_DONE_ENABLE;
    assign src_en[1] = LOW_SUPPLY_ENABLE;

    genvar t, s;
    generate
        for (t = 0; t < NT; t++) begin : g_tm
            wire gih_tm_t mask = TM_ENH[t] ? 3'b111 : 3'b011;
            assign src_set[2+3*t +: 3] = (TM_MATCH[t] | TM_FLAG_SET[t]) & mask;
            assign src_clr[2+3*t +: 3] = TM_FLAG_CLR[t];
            assign src_en[2+3*t +: 3] = TM_ENABLE[t] & mask;
        end
        for (s = 0; s < NS; s++) begin : g_src
            gih_flag u_f (
                .clk(REF_CLK),
                .rst_b(RST_B),
                .set(src_set[s]),
                .clr(src_clr[s]),
                .flag(src_flag[s]),
                .rise(src_rise[s])
            );
        end
    endgenerate

    // ==========================================================================
    // Group membership: 0 write done and low supply, then one group per timer.
    function automatic logic [NS-1:0] member(input int g);
        logic [NS-1:0] m;
        m = '0;
        if (g == 0) begin
            m[1:0] = 2'b11;
        end else if (g <= NT) begin
            m[2+3*(g-1) +: 3] = 3'b111;
        end
        return m;
    endfunction

    logic [GIH_GROUPS-1:0] grp_set, grp_clr, grp_flag, grp_rise, grp_elig, grant;
    logic any_grant, service, halted;
    genvar g;
    generate
        for (g = 0; g < GIH_GROUPS; g++) begin : g_grp
            assign grp_set[g] = |(src_rise & member(g));
            assign grp_clr[g] = GROUP_FLAG_CLR[g] | (service & grant[g]);
            assign grp_elig[g] = grp_flag[g] & GROUP_IRQ_ENABLE[g] & (|(src_flag & src_en & member(g)));
            gih_flag u_g (
                .clk(REF_CLK),
                .rst_b(RST_B),
                .set(grp_set[g]),
                .clr(grp_clr[g]),
                .flag(grp_flag[g]),
                .rise(grp_rise[g])
            );
        end
    endgenerate

    gih_prio #(.N(GIH_GROUPS)) u_prio (
        .req(grp_elig),
        .any(any_grant),
        .grant(grant)
    );

    // ==========================================================================
    // Service and return.
    logic gie, busy;
    assign service = gie & any_grant & ~STACK_FULL & ~halted & ~busy & (CORE_CMD == GIH_CMD_NONE);

    logic [GIH_VEC_W-1:0] vec_addr;
    always_comb begin
        vec_addr = GIH_VEC_BASE;
        for (int i = GIH_GROUPS - 1; i >= 0; i--) begin
            if (grant[i]) begin
                vec_addr = GIH_VEC_BASE + GIH_VEC_STEP * i[GIH_VEC_W-1:0];
            end
        end
    end

    wire is_ret = (CORE_CMD == GIH_CMD_RET) & ~halted;
    wire is_return_with_irq_enable = (CORE_CMD == GIH_CMD_RETURN_WITH_IRQ_ENABLE) & ~halted;
    wire is_halt = (CORE_CMD == GIH_CMD_HALT) & ~halted;

    wire next_gie = service ? 1'b0 :
                    is_return_with_irq_enable ? 1'b1 :
                    GLOBAL_IRQ_ENABLE_SET ? 1'b1 :
                    GLOBAL_IRQ_ENABLE_CLR ? 1'b0 : gie;

    // ==========================================================================
    // Halt and wake.
    // rise wakes regardless of enables
    wire any_rise = (|src_rise) | (|grp_rise);
    wire wake_vec = gie & any_grant & ~STACK_FULL;
    // The halted output must show the new state on the edge that takes the halt or the wake.
    wire next_halted = is_halt | (halted & ~any_rise);

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            gie <= 1'b0;
            busy <= 1'b0;
            halted <= 1'b0;
            VEC_CALL <= '0;
            PUSH_PC <= 1'b0;
            POP_PC <= 1'b0;
            WAKE_RESUME <= 1'b0;
            WDT_CLEAR <= 1'b0;
            POWER_DOWN_STATUS <= GIH_PDF_RESET;
            WATCHDOG_TIMEOUT_STATUS <= GIH_TO_RESET;
        end else begin
            gie <= next_gie;
            busy <= service;
            VEC_CALL.valid <= service;
            VEC_CALL.addr <= vec_addr;
            PUSH_PC <= service;
            POP_PC <= is_ret | is_return_with_irq_enable;
            if (is_halt) begin
                halted <= 1'b1;
            end else if (halted && any_rise) begin
                halted <= 1'b0;
            end
            WAKE_RESUME <= halted & any_rise & ~wake_vec;
            WDT_CLEAR <= is_halt | CLR_WDT;
            if (is_halt) begin
                POWER_DOWN_STATUS <= 1'b1;
                WATCHDOG_TIMEOUT_STATUS <= 1'b0;
            end else begin
                if (CLR_WDT) begin
                    POWER_DOWN_STATUS <= 1'b0;
                end
                if (WDT_OVERFLOW) begin
                    WATCHDOG_TIMEOUT_STATUS <= 1'b1;
                end else if (CLR_WDT) begin
                    WATCHDOG_TIMEOUT_STATUS <= 1'b0;
                end
            end
        end
    end

    // ==========================================================================
    // Output copies; flags come from their own flip-flops.
    // state held in halt
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            GLOBAL_IRQ_ENABLE <= 1'b0;
            HALTED <= 1'b0;
            SYS_CLK_RUN <= 1'b1;
            WDT_RUN <= 1'b0;
        end else begin
            GLOBAL_IRQ_ENABLE <= next_gie;
            HALTED <= next_halted;
            SYS_CLK_RUN <= ~(halted | is_halt) | (halted & any_rise);
            WDT_RUN <= WDT_ENABLE & (WDT_FROM_SUB_CLOCK | ~(halted | is_halt));
        end
    end

    assign STORAGE_WRITE_DONE_FLAG = src_flag[0];
    assign LOW_SUPPLY_FLAG = src_flag[1];
    assign GROUP_REQUEST_FLAGS = grp_flag;
    generate
        for (t = 0; t < NT; t++) begin : g_out
            assign TM_FLAG[t] = src_flag[2+3*t +: 3];
        end
    endgenerate

endmodule
`default_nettype wire

// file: gih_ctrl_properties.sv
// Concurrent checks on the ports of the grouped interrupt and halt block.
// Assumes one clock domain; attached by the bind at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
module gih_ctrl_properties
    import gih_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic STORE_WRITE_DONE,
    input wire gih_cmd_t CORE_CMD,
    input wire logic STACK_FULL,
    input wire gih_call_t VEC_CALL,
    input wire logic PUSH_PC,
    input wire logic POP_PC,
    input wire logic GLOBAL_IRQ_ENABLE,
    input wire logic HALTED,
    input wire logic SYS_CLK_RUN,
    input wire logic WDT_CLEAR,
    input wire logic POWER_DOWN_STATUS,
    input wire logic WATCHDOG_TIMEOUT_STATUS,
    input wire logic STORAGE_WRITE_DONE_FLAG,
    input wire logic LOW_SUPPLY_FLAG,
    input wire logic [GIH_GROUPS-1:0] GROUP_REQUEST_FLAGS
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    // ========
    // Halt command and the state that it must leave one cycle later.
    sequence s_halt_cmd;
        CORE_CMD == GIH_CMD_HALT && !HALTED;
    endsequence
    sequence s_halted;
        HALTED && POWER_DOWN_STATUS && !WATCHDOG_TIMEOUT_STATUS && WDT_CLEAR && !SYS_CLK_RUN;
    endsequence
    a_flag_on_done: assert property (STORE_WRITE_DONE |=> STORAGE_WRITE_DONE_FLAG)
        else $error("write-done flag not set");
    a_group_follows: assert property ($rose(STORAGE_WRITE_DONE_FLAG) |=> GROUP_REQUEST_FLAGS[0])
        else $error("group flag did not follow member");
    a_call_cause: assert property (VEC_CALL.valid |-> $past(GLOBAL_IRQ_ENABLE) && !$past(STACK_FULL))
        else $error("call without enable or stack room");
    a_call_push: assert property (VEC_CALL.valid |-> PUSH_PC && !GLOBAL_IRQ_ENABLE)
        else $error("call without push or enable left set");
    a_group_clear: assert property (VEC_CALL.valid && VEC_CALL.addr == GIH_VEC_BASE |-> !GROUP_REQUEST_FLAGS[0])
        else $error("group flag kept after service");
    a_return_with_irq_enable_pop: assert property (CORE_CMD == GIH_CMD_RETURN_WITH_IRQ_ENABLE && !HALTED |=> POP_PC && GLOBAL_IRQ_ENABLE)
        else $error("return with enable wrong");
    a_ret_pop: assert property (CORE_CMD == GIH_CMD_RET && !HALTED && !GLOBAL_IRQ_ENABLE |=> POP_PC && !GLOBAL_IRQ_ENABLE)
        else $error("plain return wrong");
    a_halt_entry: assert property (s_halt_cmd |=> s_halted)
        else $error("halt entry state wrong");
    a_wake_on_rise: assert property (HALTED && $rose(LOW_SUPPLY_FLAG) |=> !HALTED)
        else $error("no wake on flag rise");
endmodule
bind gih_ctrl gih_ctrl_properties chk_u (.REF_CLK, .RST_B, .STORE_WRITE_DONE, .CORE_CMD, .STACK_FULL,
    .VEC_CALL, .PUSH_PC, .POP_PC, .GLOBAL_IRQ_ENABLE, .HALTED, .SYS_CLK_RUN, .WDT_CLEAR, .POWER_DOWN_STATUS,
    .WATCHDOG_TIMEOUT_STATUS, .STORAGE_WRITE_DONE_FLAG, .LOW_SUPPLY_FLAG, .GROUP_REQUEST_FLAGS);
`default_nettype wire

// file: gih_core_model.sv
// Behavioural model of the core stack that answers vector calls and returns.
// Assumes push and pop pulses arrive on the system clock.
`timescale 1ns/100ps
`default_nettype none
module gih_core_model
    import gih_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic push,
    input wire logic pop,
    input wire logic full_req,
    output logic stack_full,
    output logic [3:0] depth
);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            depth <= 4'h0;
        end else if (push && depth < GIH_DEPTH) begin
            depth <= depth + 4'h1;
        end else if (pop && depth != 4'h0) begin
            depth <= depth - 4'h1;
        end
    end
    assign stack_full = full_req || depth == GIH_DEPTH;
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the grouped interrupt and halt block.
// Assumes the stack model and the bound checker are compiled with it.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb_top
    import gih_pkg::*;
;
    typedef struct packed {logic [9:0] ev; logic v; logic [1:0] g;} gih_row_t;
    logic clk, rst_b, store, det, en, gie_set, clr, full, sub, v, push, pop, gie, halted, run, wake;
    logic wdt_run, power_down_status, sw_flag, ls_flag, stack_full;
    logic [3:0] grp_flag;
    logic [11:0] a;
    gih_cmd_t cmd_q;
    gih_tm_t [2:0] tm, tm_set, tm_flag;
    gih_call_t call;
    gih_row_t rows [11];
    int mismatches, comparisons;
    gih_ctrl dut_u (.REF_CLK(clk), .RST_B(rst_b), .STORE_WRITE_DONE(store), .LOW_SUPPLY_DET(det),
        .TM_MATCH(tm), .GLOBAL_IRQ_ENABLE_SET(gie_set), .GLOBAL_IRQ_ENABLE_CLR(1'b0),
        .STORAGE_WRITE_DONE_ENABLE(en), .LOW_SUPPLY_ENABLE(en), .TM_ENABLE({9{en}}),
        .GROUP_IRQ_ENABLE({4{en}}), .STORAGE_WRITE_DONE_CLR(clr), .LOW_SUPPLY_CLR(clr),
        .LOW_SUPPLY_SET(1'b0), .TM_FLAG_CLR({9{clr}}), .TM_FLAG_SET(tm_set), .GROUP_FLAG_CLR({4{clr}}),
        .CORE_CMD(cmd_q), .STACK_FULL(stack_full), .CLR_WDT(1'b0), .WDT_ENABLE(en),
        .WDT_FROM_SUB_CLOCK(sub), .VEC_CALL(call), .PUSH_PC(push), .POP_PC(pop),
        .GLOBAL_IRQ_ENABLE(gie), .HALTED(halted), .SYS_CLK_RUN(run), .WAKE_RESUME(wake),
        .WDT_CLEAR(), .WDT_RUN(wdt_run), .POWER_DOWN_STATUS(power_down_status), .WATCHDOG_TIMEOUT_STATUS(),
        .WDT_OVERFLOW(1'b0), .STORAGE_WRITE_DONE_FLAG(sw_flag), .LOW_SUPPLY_FLAG(ls_flag),
        .TM_FLAG(tm_flag), .GROUP_REQUEST_FLAGS(grp_flag));
    gih_core_model core_u (.clk(clk), .rst_b(rst_b), .push(push), .pop(pop), .full_req(full),
        .stack_full(stack_full), .depth());
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #50000;
        mismatches++;
        give_verdict();
    end
    // ========
    // Shared drivers; inputs change by non-blocking assignment at the rising edge.
    task automatic give_verdict();
        $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic pulse_ev(input logic [9:0] e);
        @(posedge clk);
        store <= e[0];
        tm <= e[9:1];
        @(posedge clk);
        store <= 1'b0;
        tm <= '0;
    endtask
    task automatic cmd(input gih_cmd_t c);
        @(posedge clk);
        cmd_q <= c;
        @(posedge clk);
        cmd_q <= GIH_CMD_NONE;
    endtask
    task automatic clear_all();
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
    endtask
    task automatic wait_call();
        v = 1'b0;
        for (int i = 0; i < 12 && v !== 1'b1; i++) begin
            @(negedge clk);
            v = call.valid;
            a = call.addr;
        end
    endtask
    // ========
    initial begin
        {rst_b, store, det, en, gie_set, clr, full, sub} = '0;
        tm = '0;
        tm_set = '0;
        cmd_q = GIH_CMD_NONE;
        mismatches = 0;
        comparisons = 0;
        rows = '{'{10'h001, 1'b1, 2'h0}, '{10'h002, 1'b1, 2'h1}, '{10'h004, 1'b1, 2'h1},
            '{10'h008, 1'b0, 2'h1}, '{10'h010, 1'b1, 2'h2}, '{10'h020, 1'b1, 2'h2},
            '{10'h040, 1'b0, 2'h2}, '{10'h080, 1'b1, 2'h3}, '{10'h100, 1'b1, 2'h3},
            '{10'h200, 1'b1, 2'h3}, '{10'h081, 1'b1, 2'h0}};
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        `CHK({gie, halted, run, power_down_status, sw_flag, grp_flag}, 9'h040)
        @(posedge clk);
        en <= 1'b1;
        gie_set <= 1'b1;
        @(posedge clk);
        gie_set <= 1'b0;
        foreach (rows[i]) begin
            pulse_ev(rows[i].ev);
            wait_call();
            `CHK(v, rows[i].v)
            if (rows[i].v) begin
                `CHK(a, GIH_VEC_BASE + GIH_VEC_STEP * rows[i].g)
            end
            `CHK(grp_flag[rows[i].g], 1'b0)
            `CHK(sw_flag | (|tm_flag), rows[i].v)
            clear_all();
            cmd(GIH_CMD_RETURN_WITH_IRQ_ENABLE);
        end
        // A request pending behind a cleared enable, then a full stack.
        @(posedge clk);
        en <= 1'b0;
        full <= 1'b1;
        pulse_ev(10'h001);
        wait_call();
        `CHK(v, 1'b0)
        @(posedge clk);
        en <= 1'b1;
        wait_call();
        `CHK(v, 1'b0)
        @(posedge clk);
        full <= 1'b0;
        wait_call();
        `CHK({v, a}, {1'b1, GIH_VEC_BASE})
        cmd(GIH_CMD_RET);
        @(negedge clk);
        `CHK(gie, 1'b0)
        clear_all();
        pulse_ev(10'h001);
        wait_call();
        `CHK(v, 1'b0)
        @(posedge clk);
        gie_set <= 1'b1;
        @(posedge clk);
        gie_set <= 1'b0;
        wait_call();
        `CHK(v, 1'b1)
        clear_all();
        @(posedge clk);
        tm_set <= 9'h001;
        sub <= 1'b1;
        @(posedge clk);
        tm_set <= '0;
        cmd(GIH_CMD_HALT);
        @(negedge clk);
        `CHK({halted, power_down_status, run, wdt_run}, 4'b1101)
        pulse_ev(10'h002);
        repeat (4) @(negedge clk);
        `CHK(halted, 1'b1)
        @(posedge clk);
        det <= 1'b1;
        v = 1'b0;
        for (int i = 0; i < 10 && halted === 1'b1; i++) begin
            @(negedge clk);
            v = wake;
        end
        `CHK({halted, v, ls_flag, run}, 4'b0111)
        give_verdict();
    end
endmodule
`default_nettype wire
